/* File: dlsd_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module dlsd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } dlsd_fifo_s;

  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  dlsd_fifo_s st_r;
  dlsd_fifo_s st_nxt;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == PTR_LAST) ? '0 : AW'(p + 1'b1);
  endfunction

  assign o_in_ready = (st_r.cnt != CNT_FULL);
  assign o_out_valid = (st_r.cnt != '0);
  assign o_out_data = st_r.mem[st_r.rd];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr] = i_in_data;
      st_nxt.wr = ptr_inc(st_r.wr);
    end
    if (pop) begin
      st_nxt.rd = ptr_inc(st_r.rd);
    end
    if (push && !pop) begin
      st_nxt.cnt = (AW+1)'(st_r.cnt + 1'b1);
    end else if (pop && !push) begin
      st_nxt.cnt = (AW+1)'(st_r.cnt - 1'b1);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* File: dlsd_pkg.sv */
// Shared widths and counts for the sample latch and segment decoder
package dlsd_pkg;
  localparam int DLSD_DATA_W = 8;
  localparam int DLSD_UPPER_W = 5;
  localparam int DLSD_LOWER_W = 3;
  localparam int DLSD_UPPER_SEGS = 31;
  localparam int DLSD_UNIT_SRCS = 7;
  localparam int DLSD_FIFO_DEPTH = 16;
  localparam int DLSD_FIFO_AW = 4;
  localparam int DLSD_CLOCK_MHZ = 40;
  localparam int DLSD_MAX_MSPS = 125;
  localparam logic [DLSD_DATA_W-1:0] DLSD_CODE_FULL = 8'hff;
  localparam logic [DLSD_DATA_W-1:0] DLSD_CODE_ZERO = 8'h00;
  localparam logic [DLSD_UPPER_SEGS-1:0] DLSD_UPPER_ALL = 31'h7fffffff;
  localparam logic [DLSD_UNIT_SRCS-1:0] DLSD_UNIT_ALL = 7'h7f;
  localparam logic [DLSD_UPPER_SEGS-1:0] DLSD_UPPER_RST = 31'h00000000;
  localparam logic [DLSD_UNIT_SRCS-1:0] DLSD_UNIT_RST = 7'h00;

  typedef enum logic [0:0] {
    DLSD_ST_EMPTY = 1'b0,
    DLSD_ST_LOADED = 1'b1
  } dlsd_state_e;
endpackage

/* File: dlsd_src_model.sv */
// Behavioural sample source feeding words over valid and ready
`timescale 1ns/1ps
module dlsd_src_model (
  input wire logic i_clock,
  input wire logic i_ready,
  input wire logic i_slow,
  output logic o_valid,
  output logic [7:0] o_data
);
  logic [7:0] pend [$];
  initial begin
    o_valid = 1'b0;
    o_data = 8'h5a;
  end
  task automatic push(input logic [7:0] code);
    pend.push_back(code);
  endtask
  // Idle lines toggle so stale data never passes for a word
  always @(posedge i_clock) begin
    if (!o_valid || i_ready) begin
      if (o_valid) void'(pend.pop_front());
      if (pend.size() != 0 && !(i_slow && o_valid)) begin
        o_valid <= 1'b1;
        o_data <= pend[0];
      end else begin
        o_valid <= 1'b0;
        o_data <= ~o_data;
      end
    end
  end
endmodule

/* File: dlsd_top.sv */
// Sample latch and segment decoder for an 8-bit current-steering converter
// Notes on behaviour
// - Input word is captured on each rising clock edge; source presents it there.
// - One new sample accepted every clock cycle, up to maximum update rate.
// - Upper five bits become thermometer code over thirty-one equal segments.
// - Lower three bits drive seven equal unit sources, each one eighth segment.
// - Each source goes to exactly one of the two outputs at all times.
// - All-ones code steers every source to the true output.
// - All-zeros code steers every source to the complementary output.
// - Code is unsigned binary; true weight code/256, complement (255-code)/256.
`timescale 1ns/1ps
module dlsd_top (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_sample_valid,
  output logic o_sample_ready,
  input wire logic [dlsd_pkg::DLSD_DATA_W-1:0] i_parallel_sample_bits,
  output logic [dlsd_pkg::DLSD_UPPER_SEGS-1:0] o_true_current_output_upper,
  output logic [dlsd_pkg::DLSD_UNIT_SRCS-1:0] o_true_current_output_unit,
  output logic [dlsd_pkg::DLSD_UPPER_SEGS-1:0] o_complementary_current_output_upper,
  output logic [dlsd_pkg::DLSD_UNIT_SRCS-1:0] o_complementary_current_output_unit,
  output logic o_output_loaded
);
  import dlsd_pkg::*;

  typedef struct packed {
    logic ready;
    dlsd_state_e state;
    logic in_valid;
    logic [DLSD_DATA_W-1:0] in_word;
    logic [DLSD_UPPER_SEGS-1:0] upper;
    logic [DLSD_UNIT_SRCS-1:0] unit;
    logic [DLSD_UPPER_SEGS-1:0] upper_n;
    logic [DLSD_UNIT_SRCS-1:0] unit_n;
    logic [DLSD_DATA_W-1:0] code;
  } dlsd_top_s;

  dlsd_top_s st_r;
  dlsd_top_s st_nxt;
  logic rst_sync_b;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DLSD_DATA_W-1:0] fifo_out_data;
  logic sync_r1;
  logic sync_r2;

  // Reset release through two flops; assertion is still immediate
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_r1 <= 1'b0;
      sync_r2 <= 1'b0;
    end else begin
      sync_r1 <= 1'b1;
      sync_r2 <= sync_r1;
    end
  end
  assign rst_sync_b = sync_r2;

  // Thermometer decode: n low segments active
  function automatic logic [DLSD_UPPER_SEGS-1:0] thermo31(input logic [DLSD_UPPER_W-1:0] n);
    logic [DLSD_UPPER_SEGS-1:0] t;
    t = '0;
    for (int i = 0; i < DLSD_UPPER_SEGS; i++) begin
      t[i] = (i < int'(n));
    end
    thermo31 = t;
  endfunction

  function automatic logic [DLSD_UNIT_SRCS-1:0] thermo7(input logic [DLSD_LOWER_W-1:0] n);
    logic [DLSD_UNIT_SRCS-1:0] t;
    t = '0;
    for (int i = 0; i < DLSD_UNIT_SRCS; i++) begin
      t[i] = (i < int'(n));
    end
    thermo7 = t;
  endfunction

  // Weight in unit steps: one upper segment equals eight unit sources
  function automatic int steer_weight(
    input logic [DLSD_UPPER_SEGS-1:0] segs,
    input logic [DLSD_UNIT_SRCS-1:0] units
  );
    steer_weight = (DLSD_UNIT_SRCS + 1) * $countones(segs) + $countones(units);
  endfunction

  // FIFO absorbs bursts; drained one word per clock so the decoder never stalls
  dlsd_fifo #(
    .WIDTH(DLSD_DATA_W),
    .DEPTH(DLSD_FIFO_DEPTH),
    .AW(DLSD_FIFO_AW)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_b(rst_sync_b),
    .i_in_valid(st_r.in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(st_r.in_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(1'b1),
    .o_out_data(fifo_out_data)
  );

  always_comb begin
    st_nxt = st_r;
    // Edge-triggered capture; a word held back by a full FIFO stays put
    if (!st_r.in_valid || fifo_in_ready) begin
      st_nxt.in_valid = i_sample_valid;
      st_nxt.in_word = i_parallel_sample_bits;
    end
    if (fifo_out_valid) begin
      st_nxt.state = DLSD_ST_LOADED;
      st_nxt.code = fifo_out_data;
      st_nxt.upper = thermo31(fifo_out_data[DLSD_DATA_W-1 -: DLSD_UPPER_W]);
      st_nxt.unit = thermo7(fifo_out_data[DLSD_LOWER_W-1:0]);
      // Complement driven from its own flop so both halves change on one edge
      st_nxt.upper_n = ~thermo31(fifo_out_data[DLSD_DATA_W-1 -: DLSD_UPPER_W]);
      st_nxt.unit_n = ~thermo7(fifo_out_data[DLSD_LOWER_W-1:0]);
    end
    // Registered ready: the FIFO is popped whenever it holds a word, so it
    // has room next cycle if it is popping now or is not full now
    st_nxt.ready = !st_nxt.in_valid || fifo_out_valid || fifo_in_ready;
  end

  always_ff @(posedge i_clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= '0;
      st_r.upper_n <= DLSD_UPPER_ALL;
      st_r.unit_n <= DLSD_UNIT_ALL;
      st_r.ready <= 1'b1;
      st_r.state <= DLSD_ST_EMPTY;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sample_ready = st_r.ready;
  assign o_true_current_output_upper = st_r.upper;
  assign o_true_current_output_unit = st_r.unit;
  assign o_complementary_current_output_upper = st_r.upper_n;
  assign o_complementary_current_output_unit = st_r.unit_n;
  assign o_output_loaded = (st_r.state == DLSD_ST_LOADED);

  AST_STEER_EXCLUSIVE: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    ((st_r.upper ^ st_r.upper_n) == DLSD_UPPER_ALL) && ((st_r.unit ^ st_r.unit_n) == DLSD_UNIT_ALL))
    else $error("source not steered to exactly one output");
  AST_ALL_ONES: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (st_r.code == DLSD_CODE_FULL && o_output_loaded) |-> (st_r.upper == DLSD_UPPER_ALL && st_r.unit == DLSD_UNIT_ALL))
    else $error("full code not steered to true output");
  AST_ALL_ZEROS: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (st_r.code == DLSD_CODE_ZERO && o_output_loaded) |-> (st_r.upper_n == DLSD_UPPER_ALL && st_r.unit_n == DLSD_UNIT_ALL))
    else $error("zero code not steered to complement");
  AST_UPPER_COUNT: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    o_output_loaded |-> ($countones(st_r.upper) == int'(st_r.code[7:3])))
    else $error("upper segment count wrong");
  AST_UNIT_COUNT: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    o_output_loaded |-> ($countones(st_r.unit) == int'(st_r.code[2:0])))
    else $error("unit source count wrong");
  AST_WEIGHT: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    o_output_loaded |-> (8 * $countones(st_r.upper) + $countones(st_r.unit) == int'(st_r.code)))
    else $error("true output weight not equal to code");
  AST_CAPTURE: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (i_sample_valid && o_sample_ready) |=> (st_r.in_valid && st_r.in_word == $past(i_parallel_sample_bits)))
    else $error("sample not captured on rising edge");
  AST_THROUGHPUT: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    fifo_out_valid |=> (st_r.code == $past(fifo_out_data) && o_output_loaded))
    else $error("decoder missed a sample");

  AST_UPPER_THERMO: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (((st_r.upper >> 1) & ~st_r.upper) == DLSD_UPPER_RST))
    else $error("upper segments not a thermometer code");
  AST_UNIT_THERMO: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (((st_r.unit >> 1) & ~st_r.unit) == DLSD_UNIT_RST))
    else $error("unit sources not a thermometer code");
  AST_COMPL_WEIGHT: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    o_output_loaded |-> (steer_weight(st_r.upper_n, st_r.unit_n) == int'(DLSD_CODE_FULL) - int'(st_r.code)))
    else $error("complementary weight not full code minus code");
  AST_COMPL_UPPER_COUNT: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    o_output_loaded |-> ($countones(st_r.upper_n) == DLSD_UPPER_SEGS - int'(st_r.code[7:3])))
    else $error("complementary upper segment count wrong");
  AST_WEIGHT_SUM: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (steer_weight(st_r.upper, st_r.unit) + steer_weight(st_r.upper_n, st_r.unit_n) == int'(DLSD_CODE_FULL)))
    else $error("sources not shared out between the two outputs");
  AST_ZERO_TRUE_EMPTY: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (st_r.code == DLSD_CODE_ZERO && o_output_loaded) |-> (st_r.upper == DLSD_UPPER_RST && st_r.unit == DLSD_UNIT_RST))
    else $error("zero code left current on true output");
  AST_FULL_COMPL_EMPTY: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (st_r.code == DLSD_CODE_FULL && o_output_loaded) |-> (st_r.upper_n == DLSD_UPPER_RST && st_r.unit_n == DLSD_UNIT_RST))
    else $error("full code left current on complement");

  // Ready is a flop copy of the real capacity; a mismatch would drop a word
  AST_READY_ALWAYS: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    o_sample_ready)
    else $error("sample refused");
  AST_READY_EXACT: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (o_sample_ready == (!st_r.in_valid || fifo_in_ready)))
    else $error("ready does not match capture capacity");
  AST_IDLE_NO_WORD: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (!i_sample_valid && o_sample_ready) |=> !st_r.in_valid)
    else $error("word captured without valid");
  AST_PUSH_THROUGH: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (st_r.in_valid && fifo_in_ready) |=> fifo_out_valid)
    else $error("captured word not passed on");
  AST_ORDER_KEPT: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    (st_r.in_valid && fifo_in_ready) |-> ##2 (st_r.code == $past(st_r.in_word, 2)))
    else $error("decoded word out of order");
  AST_HOLD_OUTPUTS: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    !fifo_out_valid |=> ($stable(st_r.upper) && $stable(st_r.unit) && $stable(st_r.code)
      && $stable(st_r.upper_n) && $stable(st_r.unit_n)))
    else $error("outputs changed without a new word");

  // Before the first word the outputs keep the reset steering
  AST_LOADED_STICKY: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    o_output_loaded |=> o_output_loaded)
    else $error("loaded flag dropped");
  AST_LOADED_RISE: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    $rose(o_output_loaded) |-> $past(fifo_out_valid))
    else $error("loaded without a decoded word");
  AST_EMPTY_STEER: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    !o_output_loaded |-> (st_r.upper == DLSD_UPPER_RST && st_r.unit == DLSD_UNIT_RST
      && st_r.upper_n == DLSD_UPPER_ALL && st_r.unit_n == DLSD_UNIT_ALL))
    else $error("steering moved before the first word");
  AST_CODE_WHEN_EMPTY: assert property (@(posedge i_clock) disable iff (!rst_sync_b)
    !o_output_loaded |-> (st_r.code == DLSD_CODE_ZERO))
    else $error("code held before the first word");
endmodule

/* File: test_dac_input_latch_segment_decoder.sv */
// Self-checking bench for the sample latch and segment decoder
`timescale 1ns/1ps
module test_dac_input_latch_segment_decoder;
  import dlsd_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic slow = 1'b0;
  logic valid, ready, loaded, have;
  logic [7:0] data, exp_code;
  logic [30:0] t_up, c_up;
  logic [6:0] t_un, c_un;
  logic [2:0] pv = 3'h0;
  logic [7:0] pc [3];
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  always #12.5 i_clock = ~i_clock;
  dlsd_src_model src (.i_clock(i_clock), .i_ready(ready), .i_slow(slow), .o_valid(valid), .o_data(data));
  dlsd_top uut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_sample_valid(valid), .o_sample_ready(ready),
    .i_parallel_sample_bits(data), .o_true_current_output_upper(t_up), .o_true_current_output_unit(t_un),
    .o_complementary_current_output_upper(c_up), .o_complementary_current_output_unit(c_un),
    .o_output_loaded(loaded));
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [47:0] decode(input logic [7:0] c);
    logic [31:0] up;
    logic [7:0] un;
    up = (32'h1 << c[7:3]) - 32'h1;
    un = (8'h1 << c[2:0]) - 8'h1;
    return {10'h0, up[30:0], un[6:0]};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Decoded word appears two edges after the edge that takes it
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    pv <= i_rst_b ? {pv[1:0], valid & ready} : 3'h0;
    pc[0] <= data;
    pc[1] <= pc[0];
    pc[2] <= pc[1];
    if (cycles == 2000) begin
      mismatches++;
      final_report();
    end
  end
  initial have = 1'b0;
  always @(negedge i_clock) begin
    if (i_rst_b) begin
      if (pv[2]) begin
        have = 1'b1;
        exp_code = pc[2];
      end
      check({47'h0, loaded}, {47'h0, have});
      if (valid) check({47'h0, ready}, 48'h1);
      if (have) begin
        check({10'h0, t_up, t_un}, decode(exp_code));
        check({10'h0, c_up, c_un}, decode(exp_code) ^ {10'h0, 38'h3fffffffff});
        check(48'($countones(t_up) * 8 + $countones(t_un)), {40'h0, exp_code});
      end
    end else begin
      have = 1'b0;
    end
  end
  task automatic drain();
    for (int n = 0; n < 400 && (src.pend.size() != 0 || valid); n++) @(posedge i_clock);
    repeat (4) @(posedge i_clock);
  endtask
  task automatic test_idle();
    check({47'h0, loaded}, 48'h0);
    $display("test idle done");
  endtask
  task automatic test_extremes();
    src.push(DLSD_CODE_FULL);
    drain();
    check({10'h0, t_up, t_un}, {10'h0, DLSD_UPPER_ALL, DLSD_UNIT_ALL});
    check({10'h0, c_up, c_un}, 48'h0);
    src.push(DLSD_CODE_ZERO);
    drain();
    check({10'h0, c_up, c_un}, {10'h0, DLSD_UPPER_ALL, DLSD_UNIT_ALL});
    check({10'h0, t_up, t_un}, 48'h0);
    $display("test extremes done");
  endtask
  task automatic test_sweep();
    for (int i = 0; i < 256; i++) src.push(8'(i));
    drain();
    $display("test sweep done");
  endtask
  task automatic test_slow();
    slow <= 1'b1;
    src.push(8'h07);
    src.push(8'h08);
    src.push(8'hf8);
    src.push(8'h80);
    drain();
    slow <= 1'b0;
    $display("test slow done");
  endtask
  task automatic test_reset();
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    check({10'h0, t_up, t_un}, 48'h0);
    check({10'h0, c_up, c_un}, {10'h0, DLSD_UPPER_ALL, DLSD_UNIT_ALL});
    check({47'h0, loaded}, 48'h0);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clock);
    check({47'h0, loaded}, 48'h0);
    src.push(8'h3c);
    drain();
    check({10'h0, t_up, t_un}, decode(8'h3c));
    $display("test reset done");
  endtask
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clock);
    test_idle();
    test_extremes();
    test_sweep();
    test_slow();
    test_reset();
    final_report();
  end
endmodule
